// *** rtl/sfelu_regs.svh ***
`ifndef SFELU_REGS_SVH
`define SFELU_REGS_SVH

// register file geometry
`define SFELU_NUM_GPR      16
`define SFELU_GPR_W        64
`define SFELU_DWORD_W      32
`define SFELU_IDX_W        4
// register indices of the two frame pointers
`define SFELU_IDX_STACK    4'h4
`define SFELU_IDX_FRAME    4'h5
// operand widths
`define SFELU_DEPTH_W      5
`define SFELU_STORE_W      16
// one doubleword stack slot, in bytes
`define SFELU_DWORD_BYTES  32'h00000004
// reset value of every general-purpose register
`define SFELU_GPR_RST      64'h0000000000000000

`endif

// *** rtl/sfelu_pkg.sv ***
package sfelu_pkg;

   typedef enum logic
   {
      SFELU_OP_ENTER = 1'b0,
      SFELU_OP_LEAVE = 1'b1
   } sfelu_op_t;

   typedef enum logic [2:0]
   {
      SFELU_ST_IDLE    = 3'b000,
      SFELU_ST_SAVE_FB = 3'b001,
      SFELU_ST_FETCH   = 3'b010,
      SFELU_ST_COPY    = 3'b011,
      SFELU_ST_PUSH_FR = 3'b100,
      SFELU_ST_COMMIT  = 3'b101,
      SFELU_ST_RELEASE = 3'b110,
      SFELU_ST_POP     = 3'b111
   } sfelu_state_t;

   typedef struct packed
   {
      sfelu_op_t   op;
      logic [4:0]  depth;
      logic [15:0] storage;
   } sfelu_cmd_t;

   typedef struct packed
   {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sfelu_mem_t;

   typedef struct packed
   {
      logic        en;
      logic        register_extension_prefix;
      logic        wide;
      logic [3:0]  idx;
      logic [63:0] data;
   } sfelu_gpr_wr_t;

endpackage

// *** rtl/sfelu_top.sv ***
`timescale 1ns/1ps
`include "sfelu_regs.svh"

module sfelu_top
(
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire logic                   start,
   input  wire sfelu_pkg::sfelu_cmd_t  cmd,
   input  wire logic                   mode64,
   input  wire sfelu_pkg::sfelu_gpr_wr_t gpr_wr,
   input  wire logic [3:0]             rd_idx,
   input  wire logic                   rd_prefix,
   input  wire logic                   mem_ack,
   input  wire logic [31:0]            mem_rdata,
   output sfelu_pkg::sfelu_mem_t       mem,
   output logic [63:0]                 rd_data,
   output logic                        busy,
   output logic                        done
);
   import sfelu_pkg::*;

   logic [63:0]  gpr_reg [`SFELU_NUM_GPR];
   sfelu_state_t state_reg;
   sfelu_cmd_t   cmd_reg;
   sfelu_mem_t   mem_reg;
   logic [4:0]   cnt_reg;
   logic [31:0]  walk_reg;
   logic [31:0]  latched_frame_value_reg;
   logic [63:0]  rd_data_reg;
   logic         busy_reg;
   logic         done_reg;
   logic [31:0]  sp_cur;
   logic [31:0]  fb_cur;
   logic         step_ok;

   // upper eight registers only decode in 64-bit mode with the prefix present
   function automatic logic [3:0] eff_idx(input logic [3:0] idx, input logic pfx,
                                          input logic m64);
      eff_idx = {idx[3] & pfx & m64, idx[2:0]};
   endfunction

   assign sp_cur  = gpr_reg[`SFELU_IDX_STACK][31:0];
   assign fb_cur  = gpr_reg[`SFELU_IDX_FRAME][31:0];
   assign step_ok = mem_reg.req & mem_ack;

   // register file; stack pointer moves on each completed push or pop, not on display fetch reads
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < `SFELU_NUM_GPR; i++)
            gpr_reg[i] <= `SFELU_GPR_RST;
      end
      else
      begin
         // software writes are held off while a frame operation owns the pointers
         if (gpr_wr.en && !busy_reg)
         begin
            if (mode64 && gpr_wr.register_extension_prefix && gpr_wr.wide)
               gpr_reg[eff_idx(gpr_wr.idx, gpr_wr.register_extension_prefix, mode64)]
                  <= gpr_wr.data;
            else
               gpr_reg[eff_idx(gpr_wr.idx, gpr_wr.register_extension_prefix, mode64)]
                  <= {32'h00000000, gpr_wr.data[31:0]};
         end
         unique case (state_reg)
            SFELU_ST_IDLE, SFELU_ST_FETCH:
            begin
            end
            SFELU_ST_SAVE_FB, SFELU_ST_COPY, SFELU_ST_PUSH_FR:
               if (step_ok)
                  gpr_reg[`SFELU_IDX_STACK] <= {32'h00000000, sp_cur - `SFELU_DWORD_BYTES};
            SFELU_ST_COMMIT:
               if (cmd_reg.op == SFELU_OP_ENTER)
               begin
                  gpr_reg[`SFELU_IDX_FRAME] <= {32'h00000000, latched_frame_value_reg};
                  gpr_reg[`SFELU_IDX_STACK] <= {32'h00000000, sp_cur - {16'h0000, cmd_reg.storage}};
               end
            SFELU_ST_RELEASE:
               gpr_reg[`SFELU_IDX_STACK] <= {32'h00000000, fb_cur};
            SFELU_ST_POP:
               if (step_ok)
               begin
                  gpr_reg[`SFELU_IDX_FRAME] <= {32'h00000000, mem_rdata};
                  gpr_reg[`SFELU_IDX_STACK] <= {32'h00000000, sp_cur + `SFELU_DWORD_BYTES};
               end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         rd_data_reg <= `SFELU_GPR_RST;
      else
         rd_data_reg <= gpr_reg[eff_idx(rd_idx, rd_prefix, mode64)];
   end

   // sequencer: one memory access outstanding at a time, held until acknowledged
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg               <= SFELU_ST_IDLE;
         cmd_reg                 <= '0;
         mem_reg                 <= '0;
         cnt_reg                 <= 5'h00;
         walk_reg                <= 32'h00000000;
         latched_frame_value_reg <= 32'h00000000;
         busy_reg                <= 1'b0;
         done_reg                <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         unique case (state_reg)
            SFELU_ST_IDLE:
            begin
               if (start)
               begin
                  cmd_reg  <= cmd;
                  busy_reg <= 1'b1;
                  cnt_reg  <= cmd.depth - 5'h01;
                  walk_reg <= fb_cur;
                  if (cmd.op == SFELU_OP_ENTER)
                  begin
                     state_reg <= SFELU_ST_SAVE_FB;
                     mem_reg   <= '{req: 1'b1, we: 1'b1, addr: sp_cur - `SFELU_DWORD_BYTES,
                                    wdata: fb_cur};
                  end
                  else
                  begin
                     state_reg <= SFELU_ST_RELEASE;
                  end
               end
            end
            SFELU_ST_SAVE_FB:
            begin
               if (step_ok)
               begin
                  latched_frame_value_reg <= sp_cur - `SFELU_DWORD_BYTES;
                  if (cmd_reg.depth == 5'h00)
                  begin
                     mem_reg   <= '0;
                     state_reg <= SFELU_ST_COMMIT;
                  end
                  else if (cmd_reg.depth == 5'h01)
                  begin
                     // nothing to copy at the outermost level
                     mem_reg   <= '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h00000008,
                                    wdata: sp_cur - `SFELU_DWORD_BYTES};
                     state_reg <= SFELU_ST_PUSH_FR;
                  end
                  else
                  begin
                     walk_reg  <= walk_reg - `SFELU_DWORD_BYTES;
                     mem_reg   <= '{req: 1'b1, we: 1'b0, addr: walk_reg - `SFELU_DWORD_BYTES,
                                    wdata: 32'h00000000};
                     state_reg <= SFELU_ST_FETCH;
                  end
               end
            end
            SFELU_ST_FETCH:
               if (step_ok)
               begin
                  mem_reg   <= '{req: 1'b1, we: 1'b1, addr: sp_cur - `SFELU_DWORD_BYTES,
                                 wdata: mem_rdata};
                  state_reg <= SFELU_ST_COPY;
               end
            SFELU_ST_COPY:
            begin
               if (step_ok)
               begin
                  cnt_reg <= cnt_reg - 5'h01;
                  if (cnt_reg == 5'h01)
                  begin
                     mem_reg   <= '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h00000008,
                                    wdata: latched_frame_value_reg};
                     state_reg <= SFELU_ST_PUSH_FR;
                  end
                  else
                  begin
                     walk_reg  <= walk_reg - `SFELU_DWORD_BYTES;
                     mem_reg   <= '{req: 1'b1, we: 1'b0, addr: walk_reg - `SFELU_DWORD_BYTES,
                                    wdata: 32'h00000000};
                     state_reg <= SFELU_ST_FETCH;
                  end
               end
            end
            SFELU_ST_PUSH_FR:
               if (step_ok)
               begin
                  mem_reg   <= '0;
                  state_reg <= SFELU_ST_COMMIT;
               end
            SFELU_ST_RELEASE:
            begin
               mem_reg   <= '{req: 1'b1, we: 1'b0, addr: fb_cur, wdata: 32'h00000000};
               state_reg <= SFELU_ST_POP;
            end
            SFELU_ST_POP:
            begin
               if (step_ok)
               begin
                  mem_reg   <= '0;
                  state_reg <= SFELU_ST_COMMIT;
               end
            end
            SFELU_ST_COMMIT:
            begin
               // pointers are written on this same edge for enter and in POP for leave, so done never runs ahead
               done_reg  <= 1'b1;
               busy_reg  <= 1'b0;
               state_reg <= SFELU_ST_IDLE;
            end
         endcase
      end
   end

   assign mem     = mem_reg;
   assign rd_data = rd_data_reg;
   assign busy    = busy_reg;
   assign done    = done_reg;

   // helper state for the checks below
   logic [31:0] chk_sp0;
   logic [31:0] chk_fb0;
   logic [5:0]  chk_reads;
   logic [3:0]  chk_widx;
   assign chk_widx = eff_idx(gpr_wr.idx, gpr_wr.register_extension_prefix, mode64);
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chk_sp0   <= 32'h00000000;
         chk_fb0   <= 32'h00000000;
         chk_reads <= 6'h00;
      end
      else if (state_reg == SFELU_ST_IDLE && start)
      begin
         chk_sp0   <= sp_cur;
         chk_fb0   <= fb_cur;
         chk_reads <= 6'h00;
      end
      else if (step_ok && !mem_reg.we && state_reg == SFELU_ST_FETCH)
      begin
         chk_reads <= chk_reads + 6'h01;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_enter_start;
      state_reg == SFELU_ST_IDLE && start && cmd.op == SFELU_OP_ENTER;
   endsequence
   sequence s_enter_end;
      done_reg && cmd_reg.op == SFELU_OP_ENTER;
   endsequence

   property p_first_push;
      s_enter_start |=> mem_reg.req && mem_reg.we && mem_reg.wdata == $past(fb_cur)
                        && mem_reg.addr == $past(sp_cur) - 32'h00000004;
   endproperty
   a_first_push: assert property (p_first_push) else $error("first push not old frame base");
   property p_copy_count;
      s_enter_end |-> chk_reads == ((cmd_reg.depth == 5'h00) ? 6'h00
                                    : {1'b0, cmd_reg.depth} - 6'h01);
   endproperty
   a_copy_count: assert property (p_copy_count) else $error("wrong number of copied pointers");
   property p_enter_frame;
      s_enter_end |-> fb_cur == chk_sp0 - 32'h00000004;
   endproperty
   a_enter_frame: assert property (p_enter_frame) else $error("frame base not at first push");
   property p_enter_stack;
      s_enter_end |-> sp_cur == chk_sp0 - {16'h0000, cmd_reg.storage}
                     - ((cmd_reg.depth == 5'h00) ? 32'h00000004
                        : {25'h0, cmd_reg.depth, 2'b00} + 32'h00000004);
   endproperty
   a_enter_stack: assert property (p_enter_stack) else $error("stack top wrong after enter");
   property p_last_push;
      state_reg == SFELU_ST_PUSH_FR && step_ok |-> mem_reg.wdata == chk_sp0 - 32'h00000004;
   endproperty
   a_last_push: assert property (p_last_push) else $error("latched frame value push wrong");
   property p_fetch_walk;
      state_reg == SFELU_ST_FETCH && mem_reg.req |->
         mem_reg.addr == chk_fb0 - {chk_reads[4:0], 2'b00} - 32'h00000004;
   endproperty
   a_fetch_walk: assert property (p_fetch_walk) else $error("display fetch address wrong");
   property p_push_step;
      step_ok && mem_reg.we |=> sp_cur == $past(sp_cur) - 32'h00000004;
   endproperty
   a_push_step: assert property (p_push_step) else $error("push did not move stack by 4");
   sequence s_leave_start;
      state_reg == SFELU_ST_IDLE && start && cmd.op == SFELU_OP_LEAVE;
   endsequence
   property p_leave_release;
      s_leave_start |=> ##1 sp_cur == chk_fb0 && mem_reg.req && !mem_reg.we
                        && mem_reg.addr == chk_fb0;
   endproperty
   a_leave_release: assert property (p_leave_release) else $error("leave did not release frame");
   property p_leave_end;
      done_reg && cmd_reg.op == SFELU_OP_LEAVE |-> sp_cur == chk_fb0 + 32'h00000004;
   endproperty
   a_leave_end: assert property (p_leave_end) else $error("stack not restored by leave");
   property p_done_idle;
      done_reg |-> !busy_reg && state_reg == SFELU_ST_IDLE && $past(state_reg) == SFELU_ST_COMMIT;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("done outside commit");
   property p_narrow_write;
      gpr_wr.en && !busy_reg && !(mode64 && gpr_wr.register_extension_prefix && gpr_wr.wide)
      && state_reg == SFELU_ST_IDLE && !start
      |=> gpr_reg[$past(chk_widx)][63:32] == 32'h00000000;
   endproperty
   a_narrow_write: assert property (p_narrow_write) else $error("narrow write kept upper half");

endmodule // sfelu_top

// *** tb/sfelu_mem_model.sv ***
`timescale 1ns/1ps
module sfelu_mem_model
(
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire sfelu_pkg::sfelu_mem_t mem,
   input  wire logic                 slow,
   output logic                      mem_ack,
   output logic [31:0]               mem_rdata
);
   import sfelu_pkg::*;
   logic [31:0] store [logic [31:0]];
   logic [64:0] log_q [$];
   logic [3:0]  lfsr;
   int          wcnt;

   initial
   begin
      mem_ack = 1'b0;
      mem_rdata = 32'h5A5A5A5A;
      lfsr = 4'h9;
      wcnt = 0;
   end

   // one access at a time; read data toggles in idle cycles and the cycle after an ack so stale use shows
   always @(posedge ref_clk)
   begin
      #1;
      lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
      if (!rstn)
      begin
         mem_ack = 1'b0;
         wcnt = 0;
      end
      else if (mem_ack)
      begin
         mem_ack = 1'b0;
         mem_rdata = ~mem_rdata;
      end
      else if (mem.req && wcnt > 0)
         wcnt--;
      else if (mem.req)
      begin
         mem_ack = 1'b1;
         if (mem.we)
            store[mem.addr] = mem.wdata;
         else
            mem_rdata = store.exists(mem.addr) ? store[mem.addr] : ~mem.addr;
         log_q.push_back({mem.we, mem.addr, mem.we ? mem.wdata : mem_rdata});
         // wait states only when asked, from 0 to 3 cycles
         wcnt = slow ? int'(lfsr[1:0]) : 0;
      end
      else
         mem_rdata = ~mem_rdata;
   end
endmodule // sfelu_mem_model

// *** tb/test_stack_frame_enter_leave_unit.sv ***
`timescale 1ns/1ps
`include "sfelu_regs.svh"
module test_stack_frame_enter_leave_unit;
   import sfelu_pkg::*;
   logic           ref_clk, rstn, start, mode64, rd_prefix, mem_ack, busy, done, slow;
   sfelu_cmd_t     cmd;
   sfelu_gpr_wr_t  gpr_wr;
   sfelu_mem_t     mem;
   logic [3:0]     rd_idx;
   logic [31:0]    mem_rdata, rs, a, b;
   logic [63:0]    rd_data;
   logic [63:0]    mreg [16];
   logic [31:0]    bmem [logic [31:0]];
   logic [64:0]    exp_q [$];
   int             num_errors, compares;

   sfelu_top dut (.ref_clk(ref_clk), .rstn(rstn), .start(start), .cmd(cmd), .mode64(mode64),
      .gpr_wr(gpr_wr), .rd_idx(rd_idx), .rd_prefix(rd_prefix), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .mem(mem), .rd_data(rd_data), .busy(busy), .done(done));
   sfelu_mem_model mem_m (.ref_clk(ref_clk), .rstn(rstn), .mem(mem), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   always #5 ref_clk = ~ref_clk;

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   function automatic logic [31:0] peek(input logic [31:0] ad);
      return bmem.exists(ad) ? bmem[ad] : ~ad;
   endfunction

   function automatic logic [3:0] eff(input logic [3:0] i, input logic p);
      return (mode64 && p) ? i : {1'b0, i[2:0]};
   endfunction

   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] i, input logic [63:0] d, input logic p, input logic w);
      gpr_wr = '{1'b1, p, w, i, d};
      tick();
      gpr_wr.en = 1'b0;
      mreg[eff(i, p)] = (mode64 && p && w) ? d : {32'h0, d[31:0]};
   endtask

   task automatic rd(input logic [3:0] i, input logic p);
      rd_idx = i;
      rd_prefix = p;
      tick();
      chk({1'b0, rd_data}, {1'b0, mreg[eff(i, p)]});
   endtask

   task automatic push(input logic [31:0] ad, input logic [31:0] d);
      exp_q.push_back({1'b1, ad, d});
      bmem[ad] = d;
   endtask

   task automatic run(input sfelu_op_t op, input logic [4:0] dp, input logic [15:0] st,
                      input logic poke);
      int          depth;
      int          n;
      logic [31:0] s0, f;
      depth = int'(dp);
      s0 = mreg[4][31:0];
      f = mreg[5][31:0];
      exp_q.delete();
      mem_m.log_q.delete();
      if (op == SFELU_OP_ENTER)
      begin
         push(s0 - 4, f);
         for (int i = 1; i < depth; i++)
         begin
            exp_q.push_back({1'b0, f - 4 * i, peek(f - 4 * i)});
            push(s0 - 4 * (i + 1), peek(f - 4 * i));
         end
         if (depth > 0)
            push(s0 - 4 * (depth + 1), s0 - 4);
         mreg[5] = {32'h0, s0 - 4};
         mreg[4] = {32'h0, s0 - 4 * (depth > 0 ? depth + 1 : 1) - st};
      end
      else
      begin
         exp_q.push_back({1'b0, f, peek(f)});
         mreg[5] = {32'h0, peek(f)};
         mreg[4] = {32'h0, f + 4};
      end
      cmd = '{op, dp, st};
      start = 1'b1;
      tick();
      start = 1'b0;
      // a second request and a register write while busy must both be dropped
      if (poke)
      begin
         start = 1'b1;
         gpr_wr = '{1'b1, 1'b0, 1'b0, `SFELU_IDX_FRAME, 64'hFFFFFFFFFFFFFFFF};
         tick();
         start = 1'b0;
         gpr_wr.en = 1'b0;
      end
      for (n = 0; n < 3000 && done !== 1'b1; n++)
         tick();
      chk(done, 1'b1);
      tick();
      chk({busy, done}, 2'b00);
      chk(mem_m.log_q.size(), exp_q.size());
      foreach (exp_q[i])
         if (i < mem_m.log_q.size())
            chk(mem_m.log_q[i], exp_q[i]);
      rd(`SFELU_IDX_STACK, 1'b0);
      rd(`SFELU_IDX_FRAME, 1'b0);
   endtask

   task automatic test_done();
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #900000;
      num_errors++;
      test_done();
   end

   initial
   begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      start = 1'b0;
      cmd = '0;
      mode64 = 1'b0;
      gpr_wr = '0;
      rd_idx = 4'h0;
      rd_prefix = 1'b0;
      slow = 1'b0;
      rs = 32'h9235;
      num_errors = 0;
      compares = 0;
      foreach (mreg[i])
         mreg[i] = `SFELU_GPR_RST;
      repeat (20) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      chk({busy, done, mem.req}, 3'b000);
      for (int m = 0; m < 2; m++)
      begin
         mode64 = m[0];
         for (int k = 0; k < 12; k++)
         begin
            a = xs();
            b = xs();
            wr(a[3:0], {a, b}, b[0], b[1]);
         end
         for (int i = 0; i < 16; i++)
            rd(4'(i), 1'b1);
      end
      // nested frames: depth 1, 2, 3, then a same-depth call
      mode64 = 1'b0;
      wr(`SFELU_IDX_STACK, 64'h8000, 1'b0, 1'b0);
      wr(`SFELU_IDX_FRAME, 64'h9000, 1'b0, 1'b0);
      bmem[32'h8000] = 32'hCAFE0001;
      mem_m.store[32'h8000] = 32'hCAFE0001;
      run(SFELU_OP_ENTER, 5'd1, 16'h000C, 1'b0);
      slow = 1'b1;
      run(SFELU_OP_ENTER, 5'd2, 16'h0010, 1'b1);
      run(SFELU_OP_ENTER, 5'd3, 16'h0800, 1'b0);
      run(SFELU_OP_ENTER, 5'd3, 16'h0008, 1'b1);
      repeat (4) run(SFELU_OP_LEAVE, 5'd0, 16'h0000, 1'b0);
      chk(mem_m.store[mreg[4][31:0]], 32'hCAFE0001);
      // every depth, random storage and wait states, each undone again
      mode64 = 1'b1;
      for (int d = 0; d < 32; d++)
      begin
         a = xs();
         slow = a[16];
         run(SFELU_OP_ENTER, 5'(d), a[15:0], a[17]);
         run(SFELU_OP_LEAVE, 5'd0, 16'h0000, 1'b0);
      end
      test_done();
   end
endmodule // test_stack_frame_enter_leave_unit
